// >>> hdl/uls_defs.svh
// Register map, field positions and reset values of the serial unit as seen by its controller.
// Functional notes
// - Arm break trigger only with power and receive on
// - Change order/level bits only with both enables off
// - Stop: clear enables first, then power
// - Start: set power first, then enables
// - On LIN keep both parity bits zero
// - While streaming judge by buffer-full flag only
// - On LIN require status 00H before each write
// - Write next byte only when buffer-full is zero
// - Wait shift-active zero before reinitialising transmitter; STOP and CONFIG wait for status 00H only while transmit is enabled, START does not wait
// - Detect transmit overrun by byte count and shift flag
// - Always read receive buffer, even after errors
// - Read error status before the receive buffer
`ifndef ULS_DEFS_SVH
`define ULS_DEFS_SVH

`define ULS_ADDR_W 4
`define ULS_DATA_W 8

`define ULS_OFF_MODE 4'h0
`define ULS_OFF_CTRL 4'h1
`define ULS_OFF_TXSTAT 4'h2
`define ULS_OFF_TXBUF 4'h3
`define ULS_OFF_RXBUF 4'h4
`define ULS_OFF_RXERR 4'h5

`define ULS_MODE_POWER 7
`define ULS_MODE_TXE 6
`define ULS_MODE_RXE 5
`define ULS_MODE_PS_HI 4
`define ULS_MODE_PS_LO 3

`define ULS_CTRL_BRK 6
`define ULS_CTRL_ORDER 1
`define ULS_CTRL_INV 0

`define ULS_TXS_FULL 1
`define ULS_TXS_SHIFT 0
`define ULS_TXS_IDLE 8'h00

`define ULS_RXERR_W 3

`define ULS_MODE_RST 8'h00
`define ULS_CTRL_RST 8'h00

`endif

// >>> hdl/uls_pkg.sv
// Types shared by the serial unit controller and its helpers.
package uls_pkg;

	typedef enum logic [2:0] {
		ULS_OP_START,
		ULS_OP_STOP,
		ULS_OP_CONFIG,
		ULS_OP_SEND,
		ULS_OP_BREAK
	} uls_op_t;

	typedef struct packed {
		logic [1:0] parity;
		logic tx_invert;
		logic bit_order;
	} uls_cfg_t;

	typedef struct packed {
		logic [2:0] err;
		logic [7:0] data;
	} uls_rx_rsp_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} uls_dev_req_t;

endpackage

// >>> hdl/uls_reg_access.sv
// Single register read or write on the device's register port.
`timescale 1ns/1ps
`include "uls_defs.svh"

module uls_reg_access
	import uls_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Request from the sequencer
	input wire logic req,
	input wire logic req_we,
	input wire logic [3:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic done,
	output logic [7:0] rdata,
	// Device register port
	output uls_dev_req_t dev,
	input wire logic [7:0] dev_rdata
);

	typedef enum logic [1:0] {ULS_A_IDLE, ULS_A_STROBE, ULS_A_CAPT} uls_acc_t;

	uls_acc_t state_r, state_nxt;
	uls_dev_req_t dev_r, dev_nxt;
	logic done_r, done_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	always_comb begin
		state_nxt = state_r;
		dev_nxt = dev_r;
		dev_nxt.we = 1'b0;
		dev_nxt.re = 1'b0;
		done_nxt = 1'b0;
		rdata_nxt = rdata_r;
		case (state_r)
			ULS_A_IDLE: begin
				if (req) begin
					dev_nxt.addr = req_addr;
					dev_nxt.wdata = req_we ? req_wdata : 8'h00;
					dev_nxt.we = req_we;
					dev_nxt.re = !req_we;
					done_nxt = req_we;
					state_nxt = req_we ? ULS_A_IDLE : ULS_A_STROBE;
				end
			end
			// The device answers a read in the cycle after the strobe.
			ULS_A_STROBE: state_nxt = ULS_A_CAPT;
			ULS_A_CAPT: begin
				rdata_nxt = dev_rdata;
				done_nxt = 1'b1;
				state_nxt = ULS_A_IDLE;
			end
			default: state_nxt = ULS_A_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ULS_A_IDLE;
			dev_r <= '0;
			done_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			dev_r <= dev_nxt;
			done_r <= done_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign dev = dev_r;
	assign done = done_r;
	assign rdata = rdata_r;

endmodule // uls_reg_access

// >>> hdl/uls_pend_counter.sv
// Saturating up/down counter of pending events.
`timescale 1ns/1ps

module uls_pend_counter #(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Events
	input wire logic inc,
	input wire logic dec,
	input wire logic clr,
	output logic [CNT_W-1:0] count
);

	generate
		if (CNT_W < 2) begin : g_bad_width
			$error("uls_pend_counter needs CNT_W of at least 2");
		end
	endgenerate

	logic [CNT_W-1:0] count_r, count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (clr) begin
			count_nxt = '0;
		end else if (inc && !dec && !(&count_r)) begin
			count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
		end else if (dec && !inc && (|count_r)) begin
			count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count = count_r;

endmodule // uls_pend_counter

// >>> hdl/uls_host_ctrl.sv
// Controller that runs the serial unit through its registers on behalf of a user port.
`timescale 1ns/1ps
`include "uls_defs.svh"

module uls_host_ctrl
	import uls_pkg::*;
#(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// User command port
	input wire logic cmd_valid,
	input wire uls_op_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic lin_mode,
	output logic cmd_ready,
	output logic cmd_done,
	output logic cmd_err,
	// Received frames
	output logic rx_valid,
	output uls_rx_rsp_t rx_rsp,
	// Status
	output logic unit_powered,
	output logic break_armed,
	output logic tx_overrun,
	// Device register port and its event lines
	output uls_dev_req_t dev,
	input wire logic [7:0] dev_rdata,
	input wire logic tx_done_irq,
	input wire logic rx_done_irq
);

	typedef enum logic [3:0] {
		ULS_S_IDLE, ULS_S_PWR_ON, ULS_S_ENABLE, ULS_S_QUIESCE, ULS_S_DISABLE, ULS_S_PWR_OFF,
		ULS_S_CFG_HOLD, ULS_S_CFG_WR, ULS_S_CFG_RESTORE, ULS_S_BRK_WR, ULS_S_TX_POLL,
		ULS_S_TX_WR, ULS_S_TX_SVC, ULS_S_RX_ERR, ULS_S_RX_BUF
	} uls_state_t;

	uls_state_t state_r, state_nxt, ret_r, ret_nxt;
	logic issued_r, issued_nxt;
	logic [7:0] mode_r, mode_nxt;
	uls_cfg_t cfg_r, cfg_nxt;
	logic [7:0] txbyte_r, txbyte_nxt;
	logic [2:0] err_r, err_nxt;
	logic rx_pend_r, rx_pend_nxt;
	logic armed_r, armed_nxt;
	logic over_r, over_nxt;
	logic ready_r, ready_nxt;
	logic done_r, done_nxt;
	logic cerr_r, cerr_nxt;
	logic rxv_r, rxv_nxt;
	uls_rx_rsp_t rsp_r, rsp_nxt;

	logic acc_req, acc_we, acc_done;
	logic [3:0] acc_addr;
	logic [7:0] acc_wdata, acc_rdata;
	logic bytes_inc, irq_dec, cnt_clr;
	logic [CNT_W-1:0] bytes_out, irq_unserved;
	logic step_go;

	uls_reg_access u_acc (
		.ref_clk(ref_clk),
		.rst(rst),
		.req(acc_req),
		.req_we(acc_we),
		.req_addr(acc_addr),
		.req_wdata(acc_wdata),
		.done(acc_done),
		.rdata(acc_rdata),
		.dev(dev),
		.dev_rdata(dev_rdata)
	);

	// Bytes written to the holding buffer and not yet reported done.
	uls_pend_counter #(.CNT_W(CNT_W)) u_bytes (
		.ref_clk(ref_clk),
		.rst(rst),
		.inc(bytes_inc),
		.dec(tx_done_irq),
		.clr(cnt_clr),
		.count(bytes_out)
	);

	// Transmit-done events that the controller has not yet serviced.
	uls_pend_counter #(.CNT_W(CNT_W)) u_irqs (
		.ref_clk(ref_clk),
		.rst(rst),
		.inc(tx_done_irq),
		.dec(irq_dec),
		.clr(cnt_clr),
		.count(irq_unserved)
	);

	function automatic logic [7:0] ctrl_word(input uls_cfg_t c, input logic brk);
		logic [7:0] w;
		w = `ULS_CTRL_RST;
		w[`ULS_CTRL_BRK] = brk;
		w[`ULS_CTRL_ORDER] = c.bit_order;
		w[`ULS_CTRL_INV] = c.tx_invert;
		return w;
	endfunction

	function automatic logic [7:0] mode_word(input logic pwr, input logic en, input uls_cfg_t c,
		input logic lin);
		logic [7:0] w;
		w = `ULS_MODE_RST;
		w[`ULS_MODE_POWER] = pwr;
		w[`ULS_MODE_TXE] = en;
		w[`ULS_MODE_RXE] = en;
		w[`ULS_MODE_PS_HI] = c.parity[1] & !lin;
		w[`ULS_MODE_PS_LO] = c.parity[0] & !lin;
		return w;
	endfunction

	always_comb begin
		state_nxt = state_r;
		ret_nxt = ret_r;
		issued_nxt = issued_r;
		mode_nxt = mode_r;
		cfg_nxt = cfg_r;
		txbyte_nxt = txbyte_r;
		err_nxt = err_r;
		rsp_nxt = rsp_r;
		over_nxt = over_r;
		done_nxt = 1'b0;
		cerr_nxt = 1'b0;
		rxv_nxt = 1'b0;
		acc_req = 1'b0;
		acc_we = 1'b0;
		acc_addr = `ULS_OFF_MODE;
		acc_wdata = 8'h00;
		bytes_inc = 1'b0;
		irq_dec = 1'b0;
		cnt_clr = 1'b0;
		step_go = 1'b0;
		// A new frame that arrives as the old one is taken stays pending.
		rx_pend_nxt = rx_pend_r | rx_done_irq;
		// The device drops the trigger itself once any frame has been received.
		armed_nxt = armed_r & !rx_done_irq;
		if (state_r != ULS_S_IDLE) begin
			if (!issued_r) begin
				acc_req = 1'b1;
				issued_nxt = 1'b1;
			end else if (acc_done) begin
				issued_nxt = 1'b0;
				step_go = 1'b1;
			end
		end
		case (state_r)
			ULS_S_IDLE: begin
				if (cmd_valid && ready_r) begin
					case (cmd_op)
						ULS_OP_START: begin
							over_nxt = 1'b0;
							cnt_clr = 1'b1;
							state_nxt = ULS_S_PWR_ON;
						end
						ULS_OP_STOP: begin
							ret_nxt = ULS_S_DISABLE;
							state_nxt = ULS_S_QUIESCE;
						end
						ULS_OP_CONFIG: begin
							cfg_nxt = cmd_data[3:0];
							ret_nxt = ULS_S_CFG_HOLD;
							state_nxt = ULS_S_QUIESCE;
						end
						ULS_OP_SEND: begin
							txbyte_nxt = cmd_data;
							if (mode_r[`ULS_MODE_TXE]) begin
								state_nxt = ULS_S_TX_POLL;
							end else begin
								cerr_nxt = 1'b1;
							end
						end
						ULS_OP_BREAK: begin
							if (mode_r[`ULS_MODE_POWER] && mode_r[`ULS_MODE_RXE]) begin
								state_nxt = ULS_S_BRK_WR;
							end else begin
								cerr_nxt = 1'b1;
							end
						end
						default: cerr_nxt = 1'b1;
					endcase
				end else if (rx_pend_r) begin
					rx_pend_nxt = rx_done_irq;
					state_nxt = ULS_S_RX_ERR;
				end else if (|irq_unserved) begin
					state_nxt = ULS_S_TX_SVC;
				end
			end
			ULS_S_PWR_ON: begin
				acc_wdata = mode_word(1'b1, 1'b0, cfg_r, lin_mode);
				acc_we = 1'b1;
				if (step_go) begin
					mode_nxt = acc_wdata;
					state_nxt = ULS_S_ENABLE;
				end
			end
			ULS_S_ENABLE: begin
				acc_wdata = mode_word(1'b1, 1'b1, cfg_r, lin_mode);
				acc_we = 1'b1;
				if (step_go) begin
					mode_nxt = acc_wdata;
					done_nxt = 1'b1;
					state_nxt = ULS_S_IDLE;
				end
			end
			ULS_S_QUIESCE: begin
				// Reinitialising while a frame still shifts corrupts it.
				acc_addr = `ULS_OFF_TXSTAT;
				if (step_go && (!mode_r[`ULS_MODE_TXE] || acc_rdata == `ULS_TXS_IDLE)) begin
					state_nxt = ret_r;
				end
			end
			ULS_S_DISABLE: begin
				acc_wdata = mode_word(1'b1, 1'b0, cfg_r, lin_mode);
				acc_we = 1'b1;
				if (step_go) begin
					mode_nxt = acc_wdata;
					state_nxt = ULS_S_PWR_OFF;
				end
			end
			ULS_S_PWR_OFF: begin
				acc_wdata = `ULS_MODE_RST;
				acc_we = 1'b1;
				if (step_go) begin
					mode_nxt = acc_wdata;
					armed_nxt = 1'b0;
					done_nxt = 1'b1;
					state_nxt = ULS_S_IDLE;
				end
			end
			ULS_S_CFG_HOLD: begin
				acc_wdata = mode_word(mode_r[`ULS_MODE_POWER], 1'b0, cfg_r, lin_mode);
				acc_we = 1'b1;
				if (step_go) begin
					state_nxt = ULS_S_CFG_WR;
				end
			end
			ULS_S_CFG_WR: begin
				// The trigger reads back as zero, so the shadow is written, never a readback.
				acc_addr = `ULS_OFF_CTRL;
				acc_wdata = ctrl_word(cfg_r, 1'b0);
				acc_we = 1'b1;
				if (step_go) begin
					armed_nxt = 1'b0;
					state_nxt = ULS_S_CFG_RESTORE;
				end
			end
			ULS_S_CFG_RESTORE: begin
				acc_wdata = mode_word(mode_r[`ULS_MODE_POWER], mode_r[`ULS_MODE_TXE], cfg_r,
					lin_mode);
				acc_we = 1'b1;
				if (step_go) begin
					mode_nxt = acc_wdata;
					done_nxt = 1'b1;
					state_nxt = ULS_S_IDLE;
				end
			end
			ULS_S_BRK_WR: begin
				acc_addr = `ULS_OFF_CTRL;
				acc_wdata = ctrl_word(cfg_r, 1'b1);
				acc_we = 1'b1;
				if (step_go) begin
					armed_nxt = 1'b1;
					done_nxt = 1'b1;
					state_nxt = ULS_S_IDLE;
				end
			end
			ULS_S_TX_POLL: begin
				// The flag pair passes 11 while streaming, so only buffer-full counts there.
				acc_addr = `ULS_OFF_TXSTAT;
				if (step_go) begin
					if (lin_mode ? (acc_rdata == `ULS_TXS_IDLE)
						: !acc_rdata[`ULS_TXS_FULL]) begin
						state_nxt = ULS_S_TX_WR;
					end
				end
			end
			ULS_S_TX_WR: begin
				acc_addr = `ULS_OFF_TXBUF;
				acc_wdata = txbyte_r;
				acc_we = 1'b1;
				if (step_go) begin
					bytes_inc = 1'b1;
					done_nxt = 1'b1;
					state_nxt = ULS_S_IDLE;
				end
			end
			ULS_S_TX_SVC: begin
				acc_addr = `ULS_OFF_TXSTAT;
				if (step_go) begin
					irq_dec = 1'b1;
					// Two unserviced completions, or an idle shifter with bytes still owed.
					if (irq_unserved > {{(CNT_W-1){1'b0}}, 1'b1}
						|| (!acc_rdata[`ULS_TXS_SHIFT] && bytes_out > irq_unserved)) begin
						over_nxt = 1'b1;
					end
					state_nxt = ULS_S_IDLE;
				end
			end
			ULS_S_RX_ERR: begin
				acc_addr = `ULS_OFF_RXERR;
				if (step_go) begin
					err_nxt = acc_rdata[`ULS_RXERR_W-1:0];
					state_nxt = ULS_S_RX_BUF;
				end
			end
			ULS_S_RX_BUF: begin
				// Skipping this read after an error would leave the error standing.
				acc_addr = `ULS_OFF_RXBUF;
				if (step_go) begin
					rsp_nxt.err = err_r;
					rsp_nxt.data = acc_rdata;
					rxv_nxt = 1'b1;
					state_nxt = ULS_S_IDLE;
				end
			end
			default: state_nxt = ULS_S_IDLE;
		endcase
		ready_nxt = (state_nxt == ULS_S_IDLE) && !rx_pend_nxt && !(cmd_valid && ready_r);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ULS_S_IDLE;
			ret_r <= ULS_S_IDLE;
			issued_r <= 1'b0;
			mode_r <= `ULS_MODE_RST;
			cfg_r <= '0;
			txbyte_r <= 8'h00;
			err_r <= 3'h0;
			rsp_r <= '0;
			rx_pend_r <= 1'b0;
			armed_r <= 1'b0;
			over_r <= 1'b0;
			ready_r <= 1'b0;
			done_r <= 1'b0;
			cerr_r <= 1'b0;
			rxv_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ret_r <= ret_nxt;
			issued_r <= issued_nxt;
			mode_r <= mode_nxt;
			cfg_r <= cfg_nxt;
			txbyte_r <= txbyte_nxt;
			err_r <= err_nxt;
			rsp_r <= rsp_nxt;
			rx_pend_r <= rx_pend_nxt;
			armed_r <= armed_nxt;
			over_r <= over_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
			cerr_r <= cerr_nxt;
			rxv_r <= rxv_nxt;
		end
	end

	assign cmd_ready = ready_r;
	assign cmd_done = done_r;
	assign cmd_err = cerr_r;
	assign rx_valid = rxv_r;
	assign rx_rsp = rsp_r;
	assign unit_powered = mode_r[`ULS_MODE_POWER];
	assign break_armed = armed_r;
	assign tx_overrun = over_r;

endmodule // uls_host_ctrl

// >>> tb/uls_host_checker.sv
// Checker watching the register traffic and the user port of the serial unit controller.
`timescale 1ns/1ps

module uls_host_checker
	import uls_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Watched ports
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic lin_mode,
	input wire logic rx_valid,
	input wire uls_dev_req_t dev,
	input wire logic [7:0] dev_rdata
);
	logic [7:0] mode_s, ctrl_s, stat_s;
	logic stat_rd, last_err;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// The status copy is spoilt after each buffer write, so every write needs a fresh poll.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_s <= 8'h00;
			ctrl_s <= 8'h00;
			stat_s <= 8'hff;
			stat_rd <= 1'b0;
			last_err <= 1'b0;
		end else begin
			stat_rd <= dev.re && dev.addr == 4'h2;
			if (dev.we && dev.addr == 4'h0) mode_s <= dev.wdata;
			if (dev.we && dev.addr == 4'h1) ctrl_s <= dev.wdata;
			if (stat_rd) stat_s <= dev_rdata;
			else if (dev.we && dev.addr == 4'h3) stat_s <= 8'hff;
			if (dev.re) last_err <= dev.addr == 4'h5;
		end
	end
	brk_guard_a: assert property (dev.we && dev.addr == 4'h1 && dev.wdata[6] |->
		mode_s[7] && mode_s[5]) else $error("break armed while unit not ready");
	order_guard_a: assert property (dev.we && dev.addr == 4'h1 && dev.wdata[1:0] != ctrl_s[1:0]
		|-> mode_s[6:5] == 2'b00) else $error("order or level changed with enables on");
	stop_order_a: assert property (dev.we && dev.addr == 4'h0 && !dev.wdata[7]
		|-> mode_s[6:5] == 2'b00) else $error("power dropped before enables");
	start_order_a: assert property (dev.we && dev.addr == 4'h0 && dev.wdata[6:5] != 2'b00
		|-> mode_s[7] && dev.wdata[7]) else $error("enables set before power");
	lin_parity_a: assert property (lin_mode && dev.we && dev.addr == 4'h0
		|-> dev.wdata[4:3] == 2'b00) else $error("parity set in LIN use");
	lin_poll_a: assert property (lin_mode && dev.we && dev.addr == 4'h3
		|-> stat_s == 8'h00) else $error("LIN write without idle status");
	full_poll_a: assert property (dev.we && dev.addr == 4'h3 |-> !stat_s[1])
		else $error("buffer written while full");
	rx_order_a: assert property (dev.re && dev.addr == 4'h4 |-> last_err)
		else $error("receive buffer read before error status");
	rx_report_a: assert property (dev.re && dev.addr == 4'h4 |-> ##[1:4] rx_valid)
		else $error("received frame not reported");
	read_space_a: assert property (dev.re |=> !(dev.we || dev.re) [*2])
		else $error("access too soon after read");
	take_drop_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("ready held after take");
endmodule // uls_host_checker

// >>> tb/uls_dev_model.sv
// Behavioural model of the serial unit's register file, transmitter and receiver.
`timescale 1ns/1ps

module uls_dev_model
	import uls_pkg::*;
#(
	parameter int TX_CYC = 12
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port and events
	input wire uls_dev_req_t dev,
	output logic [7:0] dev_rdata,
	output logic tx_done_irq,
	output logic rx_done_irq,
	// Bench controls and observation
	input wire logic rx_go,
	input wire logic [7:0] rx_byte,
	input wire logic [2:0] rx_err,
	input wire logic dup_irq,
	output logic [7:0] mode_r,
	output logic [7:0] ctrl_r,
	output logic [7:0] last_tx,
	output logic [7:0] tx_count,
	output logic bad_wr
);
	logic full, shift, unread, irq2;
	logic [7:0] txb, shreg, rxb, rdv;
	logic [2:0] err_r;
	int cnt;
	always_comb begin
		case (dev.addr)
			4'h0: rdv = mode_r;
			4'h1: rdv = {ctrl_r[7], 1'b0, ctrl_r[5:0]};
			4'h2: rdv = {6'h00, full, shift};
			4'h4: rdv = rxb;
			4'h5: rdv = {5'h00, err_r};
			default: rdv = 8'h00;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		tx_done_irq <= irq2;
		rx_done_irq <= 1'b0;
		irq2 <= 1'b0;
		// Read data lasts one cycle; afterwards the lines alternate between its inverse and itself.
		dev_rdata <= rst ? 8'h00 : (dev.re ? rdv : ~dev_rdata);
		if (rst) begin
			{mode_r, ctrl_r, last_tx, tx_count, txb, shreg, rxb} <= '0;
			{full, shift, unread, bad_wr, err_r} <= '0;
			cnt <= 0;
		end else begin
			if (dev.we && dev.addr == 4'h0) mode_r <= dev.wdata;
			if (dev.we && dev.addr == 4'h1) ctrl_r <= dev.wdata;
			if (dev.we && dev.addr == 4'h3) begin
				bad_wr <= bad_wr | full;
				full <= 1'b1;
				txb <= dev.wdata;
			end
			if (full && !shift) begin
				{full, shift} <= 2'b01;
				shreg <= txb;
				cnt <= TX_CYC;
			end else if (shift && cnt == 0) begin
				tx_done_irq <= 1'b1;
				irq2 <= dup_irq;
				last_tx <= shreg;
				tx_count <= tx_count + 8'h01;
				shreg <= txb;
				cnt <= TX_CYC;
				// A buffer write that lands on the last shift cycle must stay pending, not vanish.
				{full, shift} <= {dev.we && dev.addr == 4'h3, full};
			end else if (shift) cnt <= cnt - 1;
			if (dev.re && dev.addr == 4'h4) begin
				unread <= 1'b0;
				err_r <= 3'h0;
			end
			// Frames arrive whole with one stop bit checked.
			if (rx_go) begin
				rxb <= rx_byte;
				err_r <= rx_err | (unread ? 3'h4 : 3'h0);
				unread <= 1'b1;
				rx_done_irq <= 1'b1;
				ctrl_r[6] <= 1'b0;
			end
		end
	end
endmodule // uls_dev_model

// >>> tb/uls_host_ctrl_test.sv
// Self-checking bench of the serial unit controller against the device model.
`timescale 1ns/1ps

module uls_host_ctrl_test;
	import uls_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, lin_mode = 1'b0;
	logic rx_go = 1'b0, dup_irq = 1'b0;
	uls_op_t cmd_op = ULS_OP_START;
	logic [7:0] cmd_data = 8'h00, rx_byte = 8'h00, dev_rdata, mode_r, ctrl_r, last_tx, tx_count;
	logic [2:0] rx_err = 3'h0;
	logic cmd_ready, cmd_done, cmd_err, rx_valid, unit_powered, break_armed, tx_overrun;
	logic tx_done_irq, rx_done_irq, bad_wr;
	uls_rx_rsp_t rx_rsp;
	uls_dev_req_t dev;
	int err_count = 0, checks_done = 0;
	always #25 ref_clk = ~ref_clk;
	uls_host_ctrl #(.CNT_W(4)) uls_host_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .lin_mode(lin_mode),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_err(cmd_err), .rx_valid(rx_valid),
		.rx_rsp(rx_rsp), .unit_powered(unit_powered), .break_armed(break_armed),
		.tx_overrun(tx_overrun), .dev(dev), .dev_rdata(dev_rdata),
		.tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq));
	uls_dev_model #(.TX_CYC(12)) uls_dev_model_inst (.ref_clk(ref_clk), .rst(rst), .dev(dev),
		.dev_rdata(dev_rdata), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
		.rx_go(rx_go), .rx_byte(rx_byte), .rx_err(rx_err), .dup_irq(dup_irq), .mode_r(mode_r),
		.ctrl_r(ctrl_r), .last_tx(last_tx), .tx_count(tx_count), .bad_wr(bad_wr));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic run(input uls_op_t op, input logic [7:0] d, input logic exp_err);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		check({n < 2000, cmd_err}, {1'b1, exp_err});
	endtask
	task automatic frame(input logic [7:0] b, input logic [2:0] e);
		int n;
		@(negedge ref_clk);
		{rx_go, rx_byte, rx_err} = {1'b1, b, e};
		@(negedge ref_clk);
		rx_go = 1'b0;
		for (n = 0; n < 200 && rx_valid !== 1'b1; n++) @(negedge ref_clk);
		check({rx_valid, rx_rsp}, {1'b1, e, b});
	endtask
	task automatic wait_tx(input logic [7:0] k);
		for (int n = 0; n < 500 && tx_count !== k; n++) @(negedge ref_clk);
		check(tx_count, k);
		repeat (10) @(negedge ref_clk);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		check(unit_powered, 1'b0);
		run(ULS_OP_START, 8'h00, 1'b0);
		check(mode_r, 8'he0);
		run(ULS_OP_CONFIG, 8'h0b, 1'b0);
		check({mode_r, ctrl_r}, 16'hf003);
		run(ULS_OP_SEND, 8'h5a, 1'b0);
		run(ULS_OP_SEND, 8'ha5, 1'b0);
		wait_tx(8'h02);
		check({bad_wr, last_tx}, 9'h0a5);
		frame(8'h3c, 3'h1);
		frame(8'hc3, 3'h0);
		run(ULS_OP_BREAK, 8'h00, 1'b0);
		check({break_armed, ctrl_r[6]}, 2'b11);
		frame(8'h00, 3'h0);
		check({break_armed, ctrl_r[6]}, 2'b00);
		lin_mode = 1'b1;
		run(ULS_OP_CONFIG, 8'h0c, 1'b0);
		check(mode_r[4:3], 2'b00);
		run(ULS_OP_SEND, 8'h96, 1'b0);
		wait_tx(8'h03);
		check(last_tx, 8'h96);
		lin_mode = 1'b0;
		dup_irq = 1'b1;
		run(ULS_OP_SEND, 8'h11, 1'b0);
		wait_tx(8'h04);
		check(tx_overrun, 1'b1);
		dup_irq = 1'b0;
		run(ULS_OP_START, 8'h00, 1'b0);
		check(tx_overrun, 1'b0);
		run(ULS_OP_STOP, 8'h00, 1'b0);
		check({unit_powered, mode_r}, 9'h000);
		run(ULS_OP_SEND, 8'h22, 1'b1);
		run(ULS_OP_BREAK, 8'h00, 1'b1);
		conclude();
	end
	initial begin
		#3000000;
		err_count++;
		conclude();
	end
endmodule // uls_host_ctrl_test

bind uls_host_ctrl uls_host_checker uls_host_checker_inst (.ref_clk(ref_clk), .rst(rst),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .lin_mode(lin_mode), .rx_valid(rx_valid),
	.dev(dev), .dev_rdata(dev_rdata));
